// ### hdl/ibrs_core.sv
// core: registers, enable reset, slave address match and SCL generation for the two-wire bus
//
// Notes on behaviour
// - own address bits 7..1 match callers
// - own address never sent as master
// - default to slave mode after enable
// - upper code bits pick prescaler values
// - lower code bits pick tap points
// - first tap delay, then spaced taps
// - scl period follows divider formula
// - sda waits hold delay after fall
// - scl tap times period, sda hold
// - results match tabulated divider values
// - enable low holds module in reset
// - other control bits ignored until enabled
// - slave waits for fresh start condition
// - master start resolves via arbitration
// - stretched low phase shortens the high phase; rate unchanged
// - registers readable and writable anytime
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module ibrs_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire ibrs_pkg::ibrs_bus_req_s bus_req,
    output logic [7:0] rd_data,
    // bus line events from the shift logic
    input wire ibrs_pkg::ibrs_line_ev_s line_ev,
    input wire logic arb_lost,
    // scl open-drain pin
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // timing and mode to the shift logic
    output logic sda_change,
    output logic module_enable,
    output logic master_mode,
    output logic addr_match,
    output logic slave_active,
    output logic [6:0] own_addr_bits
);
    import ibrs_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] own_addr;
        logic [7:0] rate;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        ibrs_mode_e mode;
        logic busy;
        logic matched;
        logic scl_low;
        logic scl_prev;
    } ibrs_core_s;

    ibrs_core_s state;
    ibrs_core_s next_state;

    logic [7:0] first_tap_delay;
    logic [7:0] tap_spacing;
    logic [11:0] half_period;
    logic [9:0] sda_hold;
    logic scl_toggle;
    logic scl_fall;
    logic enabled;
    logic run_master;

    assign enabled = state.ctrl[ibrs_ctl_enable_bit];
    // control bits other than enable only take effect once enabled
    assign run_master = enabled && state.ctrl[ibrs_ctl_master_bit];
    assign scl_fall = state.scl_prev && !scl_in;

    ibrs_rate_decode u_rate_decode (
        .bit_rate_code(state.rate[5:0]),
        .first_tap_delay(first_tap_delay),
        .tap_spacing(tap_spacing),
        .half_period(half_period),
        .sda_hold(sda_hold)
    );

    // restarts on an observed scl fall and at each toggle, never on a rise, so another device stretching scl
    // eats into our high phase and the period stays at the divider value
    ibrs_bit_timer u_bit_timer (
        .clk(clk),
        .rst_b(rst_b),
        .run(run_master),
        .scl_fall(scl_fall),
        .half_period(half_period),
        .sda_hold(sda_hold),
        .scl_toggle(scl_toggle),
        .sda_change(sda_change)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        next_state.scl_prev = scl_in;

        // registers accept access whether or not the module is enabled
        if (bus_req.wr) begin
            case (bus_req.addr)
                ibrs_off_own_addr: begin
                    next_state.own_addr = {bus_req.wdata[7:1], 1'b0};
                end
                ibrs_off_rate: begin
                    next_state.rate = {2'b00, bus_req.wdata[5:0]};
                end
                ibrs_off_ctrl: begin
                    next_state.ctrl = bus_req.wdata;
                end
                default: begin
                end
            endcase
        end

        if (bus_req.rd) begin
            case (bus_req.addr)
                ibrs_off_own_addr: next_state.rdata = state.own_addr;
                ibrs_off_rate: next_state.rdata = state.rate;
                ibrs_off_ctrl: next_state.rdata = state.ctrl;
                ibrs_off_stat: begin
                    next_state.rdata = 8'h00;
                    next_state.rdata[ibrs_stat_match_bit] = state.matched;
                    next_state.rdata[ibrs_stat_busy_bit] = state.busy;
                    next_state.rdata[ibrs_stat_slave_bit] = (state.mode == ibrs_st_slave);
                    next_state.rdata[ibrs_stat_armed_bit] = (state.mode == ibrs_st_wait_start);
                end
                default: next_state.rdata = 8'h00;
            endcase
        end

        if (!enabled) begin
            // software reset: everything but the registers is cleared
            next_state.mode = ibrs_st_off;
            next_state.busy = 1'b0;
            next_state.matched = 1'b0;
            next_state.scl_low = 1'b0;
        end else begin
            if (line_ev.start_det) begin
                next_state.busy = 1'b1;
            end
            if (line_ev.stop_det) begin
                next_state.busy = 1'b0;
            end
            // a conflicting start is settled by arbitration, then we drop back
            if (arb_lost) begin
                next_state.scl_low = 1'b0;
                // the loser falls back to slave, so it stops clocking the line
                next_state.ctrl[ibrs_ctl_master_bit] = 1'b0;
            end else if (run_master && scl_toggle) begin
                next_state.scl_low = !state.scl_low;
            end else if (!run_master) begin
                next_state.scl_low = 1'b0;
            end
            if (bus_req.wr && bus_req.addr == ibrs_off_ctrl) begin
                next_state.matched = 1'b0;
            end
            case (state.mode)
                ibrs_st_off: begin
                    // a transfer already running when enabled is ignored
                    next_state.mode = ibrs_st_wait_start;
                end
                ibrs_st_wait_start: begin
                    if (line_ev.start_det) begin
                        next_state.mode = ibrs_st_slave;
                    end
                end
                ibrs_st_slave: begin
                    // match only while slave; outgoing address comes from the data path
                    if (line_ev.call_valid && !run_master &&
                        line_ev.call_addr == state.own_addr[7:1]) begin
                        next_state.matched = 1'b1;
                    end
                    if (line_ev.start_det) begin
                        next_state.matched = 1'b0;
                    end
                end
                default: begin
                    next_state.mode = ibrs_st_off;
                end
            endcase
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state.own_addr <= ibrs_rst_own_addr;
            state.rate <= ibrs_rst_rate;
            state.ctrl <= ibrs_rst_ctrl;
            state.rdata <= 8'h00;
            state.mode <= ibrs_st_off;
            state.busy <= 1'b0;
            state.matched <= 1'b0;
            state.scl_low <= 1'b0;
            state.scl_prev <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rd_data = state.rdata;
    assign scl_out = 1'b0;
    assign scl_oe = state.scl_low;
    assign module_enable = enabled;
    assign master_mode = run_master;
    assign addr_match = state.matched;
    assign slave_active = (state.mode == ibrs_st_slave);
    assign own_addr_bits = state.own_addr[7:1];

endmodule : ibrs_core

`default_nettype wire

// ### hdl/ibrs_pkg.sv
// package: register map, field layout, rate tables and timing constants for the bit-rate and address block
package ibrs_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ibrs_off_own_addr = 8'he0;
    localparam logic [7:0] ibrs_off_rate = 8'he1;
    localparam logic [7:0] ibrs_off_ctrl = 8'he2;
    localparam logic [7:0] ibrs_off_stat = 8'he3;

    localparam logic [7:0] ibrs_rst_own_addr = 8'h00;
    localparam logic [7:0] ibrs_rst_rate = 8'h00;
    localparam logic [7:0] ibrs_rst_ctrl = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int ibrs_ctl_enable_bit = 7;
    localparam int ibrs_ctl_master_bit = 5;
    localparam int ibrs_stat_busy_bit = 5;
    localparam int ibrs_stat_match_bit = 6;
    localparam int ibrs_stat_slave_bit = 4;
    localparam int ibrs_stat_armed_bit = 3;

    // ************************************************************
    // rate tables, indexed by the three-bit fields of the rate code
    // ************************************************************
    localparam logic [7:0] ibrs_first_tap_tbl [8] = '{8'h04, 8'h04, 8'h06, 8'h06, 8'h0e, 8'h1e, 8'h3e, 8'h7e};
    localparam logic [3:0] ibrs_scl_tap_tbl [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hf};
    localparam logic [3:0] ibrs_sda_tap_tbl [8] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4};
    localparam logic [7:0] ibrs_half_extra = 8'h02;
    localparam logic [7:0] ibrs_hold_extra = 8'h03;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ibrs_bus_req_s;

    typedef struct packed {
        logic scl_fall;
        logic start_det;
        logic stop_det;
        logic [6:0] call_addr;
        logic call_valid;
    } ibrs_line_ev_s;

    typedef enum logic [1:0] {
        ibrs_st_off = 2'b00,
        ibrs_st_wait_start = 2'b01,
        ibrs_st_slave = 2'b11
    } ibrs_mode_e;

endpackage : ibrs_pkg

// ### hdl/ibrs_rate_decode.sv
// rate decoder: turns the six-bit rate code into half period, hold and tap timing
`timescale 1ns/100ps
`default_nettype none

module ibrs_rate_decode (
    // rate code
    input wire logic [5:0] bit_rate_code,
    // decoded timing
    output logic [7:0] first_tap_delay,
    output logic [7:0] tap_spacing,
    output logic [11:0] half_period,
    output logic [9:0] sda_hold
);
    import ibrs_pkg::*;

    logic [3:0] scl_tap;
    logic [3:0] sda_tap;

    always_comb begin
        first_tap_delay = ibrs_first_tap_tbl[bit_rate_code[5:3]];
        tap_spacing = 8'(8'h01 << bit_rate_code[5:3]);
        scl_tap = ibrs_scl_tap_tbl[bit_rate_code[2:0]];
        sda_tap = ibrs_sda_tap_tbl[bit_rate_code[2:0]];
        // half of the divider; the full period is twice this
        half_period = 12'(first_tap_delay) + 12'(12'(scl_tap - 4'h1) * 12'(tap_spacing))
                      + 12'(ibrs_half_extra);
        sda_hold = 10'(first_tap_delay) + 10'(10'(sda_tap - 4'h1) * 10'(tap_spacing))
                   + 10'(ibrs_hold_extra);
    end

endmodule : ibrs_rate_decode

`default_nettype wire

// ### hdl/ibrs_bit_timer.sv
// bit timer: one half-period counter, restarted by each SCL falling edge and at each toggle
`timescale 1ns/100ps
`default_nettype none

module ibrs_bit_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic run,
    input wire logic scl_fall,
    input wire logic [11:0] half_period,
    input wire logic [9:0] sda_hold,
    // timing strobes
    output logic scl_toggle,
    output logic sda_change
);
    import ibrs_pkg::*;

    typedef struct packed {
        logic [11:0] cnt;
        logic sda_done;
        logic scl_tgl;
        logic sda_chg;
    } ibrs_timer_s;

    ibrs_timer_s state;
    ibrs_timer_s next_state;

    always_comb begin
        next_state = state;
        next_state.scl_tgl = 1'b0;
        next_state.sda_chg = 1'b0;
        if (!run) begin
            next_state.cnt = 12'h000;
            // no hold strobe before the first fall: scl is still high then
            next_state.sda_done = 1'b1;
        end else if (scl_fall) begin
            // restart so a stretched low phase never corrupts the count;
            // the fall is seen one cycle late, so that cycle is counted too
            next_state.cnt = 12'h002;
            next_state.sda_done = 1'b0;
        end else begin
            next_state.cnt = state.cnt + 12'h001;
            if (!state.sda_done && state.cnt == 12'(sda_hold)) begin
                next_state.sda_chg = 1'b1;
                next_state.sda_done = 1'b1;
            end
            if (state.cnt == half_period - 12'h001) begin
                next_state.scl_tgl = 1'b1;
                next_state.cnt = 12'h000;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign scl_toggle = state.scl_tgl;
    assign sda_change = state.sda_chg;

endmodule : ibrs_bit_timer

`default_nettype wire

// ### verification/ibrs_core_properties.sv
// checker: port-level assertions for the bit-rate and address core
`timescale 1ns/100ps
`default_nettype none

module ibrs_core_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire ibrs_pkg::ibrs_bus_req_s bus_req,
    input wire logic [7:0] rd_data,
    // line side
    input wire ibrs_pkg::ibrs_line_ev_s line_ev,
    input wire logic arb_lost,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    // mode and timing
    input wire logic sda_change,
    input wire logic module_enable,
    input wire logic master_mode,
    input wire logic addr_match,
    input wire logic slave_active,
    input wire logic [6:0] own_addr_bits
);
    import ibrs_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence ctrl_wr;
        bus_req.wr && bus_req.addr == ibrs_off_ctrl;
    endsequence
    sequence addr_wr;
        bus_req.wr && bus_req.addr == ibrs_off_own_addr;
    endsequence
    sequence addr_rd;
        bus_req.rd && bus_req.addr == ibrs_off_own_addr;
    endsequence

    own_addr_a: assert property (addr_wr |=> own_addr_bits == $past(bus_req.wdata[7:1]))
        else $error("own address not taken");
    read_addr_a: assert property (addr_rd |=> rd_data == {own_addr_bits, 1'b0})
        else $error("own address read wrong");
    enable_write_a: assert property (ctrl_wr |=> module_enable == $past(bus_req.wdata[7]))
        else $error("enable bit not taken");
    master_gate_a: assert property (master_mode |-> module_enable)
        else $error("master without enable");
    off_release_a: assert property (!module_enable [*2] |-> !scl_oe && !sda_change && !scl_out)
        else $error("line timing while disabled");
    slave_idle_a: assert property (!module_enable [*2] |-> !slave_active && !addr_match)
        else $error("slave state while disabled");
    match_clear_a: assert property (ctrl_wr |=> !addr_match)
        else $error("control write kept match");
    armed_match_a: assert property ($rose(addr_match) |-> $past(slave_active))
        else $error("match before start");
    arb_release_a: assert property (arb_lost |=> !scl_oe)
        else $error("scl held after arbitration loss");
    arb_master_a: assert property (arb_lost |=> !master_mode)
        else $error("master kept after arbitration loss");
    hold_low_a: assert property (sda_change |-> !scl_in)
        else $error("sda change with scl high");
endmodule : ibrs_core_checker

bind ibrs_core ibrs_core_checker ibrs_core_checker_inst (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .line_ev(line_ev), .arb_lost(arb_lost), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_change(sda_change), .module_enable(module_enable), .master_mode(master_mode),
    .addr_match(addr_match), .slave_active(slave_active), .own_addr_bits(own_addr_bits));

`default_nettype wire

// ### verification/ibrs_line_model.sv
// line model: pulled-up scl line shared with a device that may stretch the low phase
`timescale 1ns/100ps
`default_nettype none

module ibrs_line_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // line
    input wire logic scl_oe,
    input wire logic [7:0] stretch,
    output logic scl_in
);
    logic [7:0] hold_cnt;

    // loaded while the core pulls, so the line never glitches high between the two holders
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= 8'h00;
        end else if (scl_oe) begin
            hold_cnt <= stretch;
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
        end
    end

    assign scl_in = !(scl_oe || hold_cnt != 8'h00);
endmodule : ibrs_line_model

`default_nettype wire

// ### verification/ibrs_core_tb_top.sv
// testbench: register access, slave arming and bit-rate timing of the core
`timescale 1ns/100ps
`default_nettype none

module ibrs_core_tb_top;
    import ibrs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ibrs_bus_req_s bus_req = '0;
    ibrs_line_ev_s line_ev = '0;
    logic arb_lost = 1'b0;
    logic [7:0] stretch = 8'h00;
    logic scl_in, scl_out, scl_oe, sda_change, module_enable, master_mode, addr_match, slave_active;
    logic [7:0] rd_data;
    logic [6:0] own_addr_bits;
    logic [7:0] exp_q [$];
    logic rd_d = 1'b0;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 66729;
    logic [7:0] codes [6] = '{8'h00, 8'h07, 8'h0a, 8'h16, 8'h1f, 8'h3f};
    int divs [6] = '{20, 40, 36, 104, 240, 3840};
    int holds [6] = '{7, 10, 9, 21, 33, 513};

    always #2.5 clk = ~clk;

    ibrs_core ibrs_core_inst (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .line_ev(line_ev), .arb_lost(arb_lost), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_change(sda_change), .module_enable(module_enable), .master_mode(master_mode),
        .addr_match(addr_match), .slave_active(slave_active), .own_addr_bits(own_addr_bits));
    ibrs_line_model ibrs_line_model_inst (.clk(clk), .rst_b(rst_b), .scl_oe(scl_oe), .stretch(stretch),
        .scl_in(scl_in));

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // each drive task raises its request one edge after entry; idle drops it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    endtask : rd

    task automatic idle(input int n);
        @(posedge clk);
        bus_req <= '0;
        line_ev <= '0;
        arb_lost <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic ev(input logic start, input logic [6:0] a, input logic valid);
        @(posedge clk);
        line_ev <= '{scl_fall: 1'b0, start_det: start, stop_det: 1'b0, call_addr: a, call_valid: valid};
        idle(3);
    endtask : ev

    // counts falling clock edges between scl and sda events; fixed offsets cancel out
    task automatic measure(input int dv, input int hd);
        int n;
        int m;
        while (scl_oe !== 1'b0) @(negedge clk);
        while (scl_oe !== 1'b1) @(negedge clk);
        n = 0;
        while (sda_change !== 1'b1) begin @(negedge clk); n++; end
        m = 0;
        while (scl_oe !== 1'b0) begin @(negedge clk); m++; end
        check("low tail", 12'(m), 12'(dv / 2 - hd));
        while (scl_oe !== 1'b1) begin @(negedge clk); m++; end
        check("period", 12'(n + m), 12'(dv));
    endtask : measure

    // watches the read port and compares against the oldest note
    always @(posedge clk) begin
        rd_d <= bus_req.rd;
        if (rd_d) check("rd_data", {4'h0, rd_data}, {4'h0, exp_q.pop_front()});
    end

    // a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        logic [7:0] a;
        logic [7:0] c;
        int ft;
        int sp;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        a = 8'($random(seed));
        c = {2'b00, 6'($random(seed))};
        rd(ibrs_off_own_addr, ibrs_rst_own_addr);
        rd(ibrs_off_rate, ibrs_rst_rate);
        rd(ibrs_off_ctrl, ibrs_rst_ctrl);
        rd(ibrs_off_stat, 8'h00);
        wr(ibrs_off_own_addr, a);
        wr(ibrs_off_rate, c);
        wr(ibrs_off_ctrl, 8'h20);
        wr(8'h5a, 8'hff);
        rd(8'h5a, 8'h00);
        rd(ibrs_off_own_addr, {a[7:1], 1'b0});
        rd(ibrs_off_rate, c);
        idle(20);
        check("own_addr_bits", {5'h00, own_addr_bits}, {5'h00, a[7:1]});
        check("master_mode", {11'h000, master_mode}, 12'h000);
        check("scl_oe", {11'h000, scl_oe}, 12'h000);
        wr(ibrs_off_ctrl, 8'h80);
        idle(2);
        ev(1'b0, a[7:1], 1'b1);
        check("match early", {11'h000, addr_match}, 12'h000);
        ev(1'b1, 7'h00, 1'b0);
        ev(1'b0, a[7:1] ^ 7'h01, 1'b1);
        check("match other", {11'h000, addr_match}, 12'h000);
        ev(1'b0, a[7:1], 1'b1);
        check("match own", {11'h000, addr_match}, 12'h001);
        check("slave_active", {11'h000, slave_active}, 12'h001);
        rd(ibrs_off_stat, 8'h70);
        wr(ibrs_off_ctrl, 8'h80);
        idle(2);
        check("match cleared", {11'h000, addr_match}, 12'h000);
        for (int i = 0; i < 7; i++) begin
            c = (i < 6) ? codes[i] : {2'b00, 6'($random(seed))};
            ft = ibrs_first_tap_tbl[c[5:3]];
            sp = 1 << c[5:3];
            stretch <= (i == 0) ? 8'h03 : 8'h00;
            wr(ibrs_off_rate, c);
            wr(ibrs_off_ctrl, 8'ha0);
            idle(1);
            if (i < 6) measure(divs[i], holds[i]);
            else measure(2 * (ft + (ibrs_scl_tap_tbl[c[2:0]] - 1) * sp + 2),
                         ft + (ibrs_sda_tap_tbl[c[2:0]] - 1) * sp + 3);
            @(posedge clk);
            arb_lost <= 1'b1;
            wr(ibrs_off_ctrl, 8'h00);
            idle(3);
            check("scl_oe off", {11'h000, scl_oe}, 12'h000);
            check("module_enable", {11'h000, module_enable}, 12'h000);
            rd(ibrs_off_ctrl, 8'h00);
        end
        idle(4);
        end_sim();
    end
endmodule : ibrs_core_tb_top

`default_nettype wire
